//--- core/pwr_seq_pkg.sv
// package: timing constants and states shared by both ends of the power sequencer
package pwr_seq_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned ON_HOLD_MS = 5000;
    localparam int unsigned OFF_HOLD_MS = 2000;
    localparam int unsigned SERIAL_QUIET_MS = 200;
    localparam int unsigned CMD_QUIET_MS = 300;
    localparam int unsigned EMERG_HOLD_MS = 200;
    localparam int unsigned MON_TIMEOUT_MS = 10000;
    localparam int unsigned BOOT_MS = 100;
    localparam int unsigned DETACH_MS = 50;
    // cycle counts derived from the clock rate (cycles per ms truncate, nothing rounds up)
    localparam int unsigned ON_HOLD_CYC = (ON_HOLD_MS * (CLK_HZ / 1000));
    localparam int unsigned OFF_HOLD_CYC = (OFF_HOLD_MS * (CLK_HZ / 1000));
    localparam int unsigned SERIAL_QUIET_CYC = (SERIAL_QUIET_MS * (CLK_HZ / 1000));
    localparam int unsigned CMD_QUIET_CYC = (CMD_QUIET_MS * (CLK_HZ / 1000));
    localparam int unsigned EMERG_HOLD_CYC = (EMERG_HOLD_MS * (CLK_HZ / 1000));
    localparam int unsigned MON_TIMEOUT_CYC = (MON_TIMEOUT_MS * (CLK_HZ / 1000));
    localparam int unsigned BOOT_CYC = (BOOT_MS * (CLK_HZ / 1000));
    localparam int unsigned DETACH_CYC = (DETACH_MS * (CLK_HZ / 1000));
    localparam int unsigned CNT_W = 32;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic POWER_GOOD_RESET = 1'b0;
    localparam logic PAD_RELEASED = 1'b1;
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DEV_OFF = 3'b000,
        DEV_BOOT = 3'b001,
        DEV_ON = 3'b010,
        DEV_WAIT_RELEASE = 3'b011,
        DEV_DETACH = 3'b100
    } dev_state_t;
    typedef enum logic [2:0] {
        HST_IDLE = 3'b000,
        HST_HOLD = 3'b001,
        HST_WAIT_MON = 3'b010,
        HST_QUIET = 3'b011,
        HST_EMERG = 3'b100
    } host_state_t;
endpackage : pwr_seq_pkg

//--- core/pwr_seq_if.sv
// interface: the two open-collector pads and the power-good monitor line
`timescale 1ns/1ps
interface pwr_seq_if;
    // open-collector pads: host pulls low when its enable is low
    logic toggle_o;
    logic toggle_oe_n;
    logic emergency_off_o;
    logic emergency_off_oe_n;
    logic power_good_monitor;
    // resolved pad levels, pulled up inside the module
    logic toggle_n;
    logic emergency_off_n;
    assign toggle_n = (!toggle_oe_n && !toggle_o) ? 1'b0 : 1'b1;
    assign emergency_off_n = (!emergency_off_oe_n && !emergency_off_o) ? 1'b0 : 1'b1;
    modport device (
        input toggle_n,
        input emergency_off_n,
        output power_good_monitor
    );
    modport host (
        output toggle_o,
        output toggle_oe_n,
        output emergency_off_o,
        output emergency_off_oe_n,
        input power_good_monitor
    );
endinterface : pwr_seq_if

//--- core/pwr_seq_device.sv
// module: modem-side power on/off sequencer driving the power-good monitor
`timescale 1ns/1ps
// Behaviour
// - host holds toggle low 5 s to switch on
// - monitor goes high when power-up completes
// - host sends no serial data first 200 ms
// - host waits 300 ms before any command
// - host holds toggle low 2 s to switch off
// - both off paths first send network detach
// - hardware switch-off starts only after toggle release
// - monitor goes low once powered off
// - emergency pad low 200 ms forces off
// - emergency shutdown skips network detach
// - host uses emergency shutdown only when hung; pwr_seq_host starts it on any start_emergency while idle
// - host drives no high onto pads while off
// - host only pulls pads low or releases
module pwr_seq_device #(
    parameter int unsigned ON_HOLD = pwr_seq_pkg::ON_HOLD_CYC,
    parameter int unsigned OFF_HOLD = pwr_seq_pkg::OFF_HOLD_CYC,
    parameter int unsigned EMERG_HOLD = pwr_seq_pkg::EMERG_HOLD_CYC,
    parameter int unsigned BOOT_TIME = pwr_seq_pkg::BOOT_CYC,
    parameter int unsigned DETACH_TIME = pwr_seq_pkg::DETACH_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    pwr_seq_if.device pads,
    input wire logic software_shutdown_command,
    output logic detach_request,
    output logic powered
);
    // ------------------------------------------------------------
    // pad synchronisers
    // ------------------------------------------------------------
    logic tog_meta_reg;
    logic tog_sync_reg;
    logic emg_meta_reg;
    logic emg_sync_reg;
    // pads come from another board, two flops before any use
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tog_meta_reg <= pwr_seq_pkg::PAD_RELEASED;
            tog_sync_reg <= pwr_seq_pkg::PAD_RELEASED;
            emg_meta_reg <= pwr_seq_pkg::PAD_RELEASED;
            emg_sync_reg <= pwr_seq_pkg::PAD_RELEASED;
        end else begin
            tog_meta_reg <= pads.toggle_n;
            tog_sync_reg <= tog_meta_reg;
            emg_meta_reg <= pads.emergency_off_n;
            emg_sync_reg <= emg_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // hold counters
    // ------------------------------------------------------------
    logic [pwr_seq_pkg::CNT_W-1:0] tog_cnt_reg;
    logic [pwr_seq_pkg::CNT_W-1:0] emg_cnt_reg;
    logic [pwr_seq_pkg::CNT_W-1:0] seq_cnt_reg;

    logic off_armed_reg;
    logic emg_armed_reg;

    // saturating count of how long the toggle pad has been held low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tog_cnt_reg <= '0;
        end else if (tog_sync_reg) begin
            tog_cnt_reg <= '0;
        end else if (tog_cnt_reg != '1) begin
            tog_cnt_reg <= tog_cnt_reg + 1'b1;
        end
    end

    // emergency pad hold count; a short glitch never shuts down
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            emg_cnt_reg <= '0;
        end else if (emg_sync_reg) begin
            emg_cnt_reg <= '0;
        end else if (emg_cnt_reg != '1) begin
            emg_cnt_reg <= emg_cnt_reg + 1'b1;
        end
    end

    // emergency armed once held long enough; acts on release
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            emg_armed_reg <= 1'b0;
        end else if (emg_sync_reg) begin
            emg_armed_reg <= 1'b0;
        end else if (emg_cnt_reg >= (EMERG_HOLD - 1)) begin
            emg_armed_reg <= 1'b1;
        end
    end

    logic emg_fire;
    assign emg_fire = emg_armed_reg && emg_sync_reg;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    pwr_seq_pkg::dev_state_t state_reg;
    logic tog_done;
    logic on_rel;

    assign tog_done = (tog_cnt_reg >= (OFF_HOLD - 1));
    assign on_rel = (tog_cnt_reg >= (ON_HOLD - 1));

    // off request armed while held in the on state; DEV_WAIT_RELEASE waits for release
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            off_armed_reg <= 1'b0;
        end else if (state_reg != pwr_seq_pkg::DEV_ON) begin
            off_armed_reg <= 1'b0;
        end else if (!tog_sync_reg && tog_done) begin
            off_armed_reg <= 1'b1;
        end
    end

    logic on_armed_reg;

    // switch-on also acts on release, after a full 5 s hold
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            on_armed_reg <= 1'b0;
        end else if (state_reg != pwr_seq_pkg::DEV_OFF || emg_sync_reg == 1'b0) begin
            on_armed_reg <= 1'b0;
        end else if (!tog_sync_reg && on_rel) begin
            on_armed_reg <= 1'b1;
        end
    end

    // main state; emergency overrides everything and skips detach
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= pwr_seq_pkg::DEV_OFF;
            seq_cnt_reg <= '0;
        end else if (emg_fire) begin
            state_reg <= pwr_seq_pkg::DEV_OFF;
            seq_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                pwr_seq_pkg::DEV_OFF: begin
                    if (on_armed_reg && tog_sync_reg) begin
                        state_reg <= pwr_seq_pkg::DEV_BOOT;
                        seq_cnt_reg <= '0;
                    end
                end
                pwr_seq_pkg::DEV_BOOT: begin
                    if (seq_cnt_reg >= (BOOT_TIME - 1)) begin
                        state_reg <= pwr_seq_pkg::DEV_ON;
                    end else begin
                        seq_cnt_reg <= seq_cnt_reg + 1'b1;
                    end
                end
                pwr_seq_pkg::DEV_ON: begin
                    if (software_shutdown_command) begin
                        state_reg <= pwr_seq_pkg::DEV_DETACH;
                        seq_cnt_reg <= '0;
                    end else if (off_armed_reg) begin
                        state_reg <= pwr_seq_pkg::DEV_WAIT_RELEASE;
                    end
                end
                pwr_seq_pkg::DEV_WAIT_RELEASE: begin
                    // nothing shuts down while the pad is still low
                    if (tog_sync_reg) begin
                        state_reg <= pwr_seq_pkg::DEV_DETACH;
                        seq_cnt_reg <= '0;
                    end
                end
                pwr_seq_pkg::DEV_DETACH: begin
                    if (seq_cnt_reg >= (DETACH_TIME - 1)) begin
                        state_reg <= pwr_seq_pkg::DEV_OFF;
                    end else begin
                        seq_cnt_reg <= seq_cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= pwr_seq_pkg::DEV_OFF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    logic mon_reg;
    logic det_reg;
    logic pwr_reg;

    // monitor high only in full on states, low after off
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mon_reg <= pwr_seq_pkg::POWER_GOOD_RESET;
            det_reg <= 1'b0;
            pwr_reg <= 1'b0;
        end else begin
            mon_reg <= (state_reg == pwr_seq_pkg::DEV_ON) ||
                       (state_reg == pwr_seq_pkg::DEV_WAIT_RELEASE) ||
                       (state_reg == pwr_seq_pkg::DEV_DETACH);
            det_reg <= (state_reg == pwr_seq_pkg::DEV_DETACH) && !emg_fire;
            pwr_reg <= (state_reg != pwr_seq_pkg::DEV_OFF);
        end
    end

    assign pads.power_good_monitor = mon_reg;
    assign detach_request = det_reg;
    assign powered = pwr_reg;
endmodule : pwr_seq_device

//--- core/pwr_seq_host.sv
// module: host controller that drives the open-collector pads and watches power-good
`timescale 1ns/1ps
module pwr_seq_host #(
    parameter int unsigned ON_HOLD = pwr_seq_pkg::ON_HOLD_CYC,
    parameter int unsigned OFF_HOLD = pwr_seq_pkg::OFF_HOLD_CYC,
    parameter int unsigned EMERG_HOLD = pwr_seq_pkg::EMERG_HOLD_CYC,
    parameter int unsigned CMD_QUIET = pwr_seq_pkg::CMD_QUIET_CYC,
    parameter int unsigned SERIAL_QUIET = pwr_seq_pkg::SERIAL_QUIET_CYC,
    parameter int unsigned MON_TIMEOUT = pwr_seq_pkg::MON_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    pwr_seq_if.host pads,
    input wire logic start_on,
    input wire logic start_off,
    input wire logic start_emergency,
    output logic busy,
    output logic module_on,
    output logic commands_ok,
    output logic timed_out
);
    // ------------------------------------------------------------
    // monitor synchroniser
    // ------------------------------------------------------------
    logic mon_meta_reg;
    logic mon_sync_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mon_meta_reg <= 1'b0;
            mon_sync_reg <= 1'b0;
        end else begin
            mon_meta_reg <= pads.power_good_monitor;
            mon_sync_reg <= mon_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    pwr_seq_pkg::host_state_t state_reg;
    logic [pwr_seq_pkg::CNT_W-1:0] cnt_reg;
    logic want_on_reg;
    logic tog_low_reg;
    logic emg_low_reg;
    logic to_reg;
    // one request at a time; new starts ignored unless idle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= pwr_seq_pkg::HST_IDLE;
            cnt_reg <= '0;
            want_on_reg <= 1'b0;
            tog_low_reg <= 1'b0;
            emg_low_reg <= 1'b0;
            to_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                pwr_seq_pkg::HST_IDLE: begin
                    cnt_reg <= '0;
                    if (start_emergency) begin
                        state_reg <= pwr_seq_pkg::HST_EMERG;
                        emg_low_reg <= 1'b1;
                    end else if (start_on && !mon_sync_reg) begin
                        state_reg <= pwr_seq_pkg::HST_HOLD;
                        want_on_reg <= 1'b1;
                        tog_low_reg <= 1'b1;
                        to_reg <= 1'b0;
                    end else if (start_off && mon_sync_reg) begin
                        state_reg <= pwr_seq_pkg::HST_HOLD;
                        want_on_reg <= 1'b0;
                        tog_low_reg <= 1'b1;
                        to_reg <= 1'b0;
                    end
                end
                pwr_seq_pkg::HST_HOLD: begin
                    // hold long enough, then release the pad
                    if (cnt_reg >= (want_on_reg ? ON_HOLD : OFF_HOLD)) begin
                        tog_low_reg <= 1'b0;
                        cnt_reg <= '0;
                        state_reg <= pwr_seq_pkg::HST_WAIT_MON;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                pwr_seq_pkg::HST_WAIT_MON: begin
                    // wait for the expected monitor level or give up
                    if (mon_sync_reg == want_on_reg) begin
                        cnt_reg <= '0;
                        state_reg <= pwr_seq_pkg::HST_QUIET;
                    end else if (cnt_reg >= MON_TIMEOUT) begin
                        to_reg <= 1'b1;
                        cnt_reg <= '0;
                        state_reg <= pwr_seq_pkg::HST_QUIET;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                pwr_seq_pkg::HST_QUIET: begin
                    // quiet period covers both serial and command holds
                    if (cnt_reg >= CMD_QUIET && cnt_reg >= SERIAL_QUIET) begin
                        state_reg <= pwr_seq_pkg::HST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                pwr_seq_pkg::HST_EMERG: begin
                    if (cnt_reg >= EMERG_HOLD) begin
                        emg_low_reg <= 1'b0;
                        want_on_reg <= 1'b0;
                        cnt_reg <= '0;
                        state_reg <= pwr_seq_pkg::HST_WAIT_MON;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= pwr_seq_pkg::HST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic busy_reg;
    logic on_reg;
    logic ok_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
            on_reg <= 1'b0;
            ok_reg <= 1'b0;
        end else begin
            busy_reg <= (state_reg != pwr_seq_pkg::HST_IDLE);
            on_reg <= mon_sync_reg;
            ok_reg <= (state_reg == pwr_seq_pkg::HST_IDLE) && mon_sync_reg;
        end
    end
    // pads never driven high: data stays low, only the enable moves
    assign pads.toggle_o = 1'b0;
    assign pads.toggle_oe_n = !tog_low_reg;
    assign pads.emergency_off_o = 1'b0;
    assign pads.emergency_off_oe_n = !emg_low_reg;
    assign busy = busy_reg;
    assign module_on = on_reg;
    assign commands_ok = ok_reg;
    assign timed_out = to_reg;
endmodule : pwr_seq_host

//--- verif/pwr_seq_sva.sv
// checker: pad timing and shutdown ordering between the host and device ends
`timescale 1ns/1ps
module pwr_seq_sva #(
    parameter int unsigned ON_HOLD = pwr_seq_pkg::ON_HOLD_CYC,
    parameter int unsigned OFF_HOLD = pwr_seq_pkg::OFF_HOLD_CYC,
    parameter int unsigned EMERG_HOLD = pwr_seq_pkg::EMERG_HOLD_CYC,
    parameter int unsigned BOOT_TIME = pwr_seq_pkg::BOOT_CYC,
    parameter int unsigned DETACH_TIME = pwr_seq_pkg::DETACH_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic toggle_o,
    input wire logic toggle_oe_n,
    input wire logic emergency_off_o,
    input wire logic emergency_off_oe_n,
    input wire logic power_good_monitor,
    input wire logic toggle_n,
    input wire logic emergency_off_n,
    input wire logic detach_request
);
    // sync flops plus boot count plus output register give the window
    localparam int BOOT_LO = BOOT_TIME;
    localparam int BOOT_HI = BOOT_TIME + 8;
    logic [15:0] low_cnt;
    logic [15:0] em_cnt;
    logic [15:0] det_cnt;
    logic det_seen;
    logic em_seen;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    // hold lengths; 16 bits saturate, far beyond any shortened figure
    always_ff @(posedge clk) begin
        if (!rst_b || toggle_n) low_cnt <= 16'h0000;
        else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
    end
    always_ff @(posedge clk) begin
        if (!rst_b || emergency_off_n) em_cnt <= 16'h0000;
        else if (em_cnt != 16'hFFFF) em_cnt <= em_cnt + 16'h0001;
    end
    always_ff @(posedge clk) begin
        if (!rst_b || !detach_request) det_cnt <= 16'h0000;
        else if (det_cnt != 16'hFFFF) det_cnt <= det_cnt + 16'h0001;
    end
    // cause of the next switch-off, forgotten at each switch-on
    always_ff @(posedge clk) begin
        if (!rst_b || $rose(power_good_monitor)) det_seen <= 1'b0;
        else if (detach_request) det_seen <= 1'b1;
    end
    always_ff @(posedge clk) begin
        if (!rst_b || $rose(power_good_monitor)) em_seen <= 1'b0;
        else if ($rose(emergency_off_n) && em_cnt >= EMERG_HOLD) em_seen <= 1'b1;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_on_hold_len: assert property (
        $rose(toggle_n) && !power_good_monitor |-> low_cnt >= ON_HOLD)
        else $error("switch-on hold too short");
    a_boot_delay: assert property (
        $rose(toggle_n) && !power_good_monitor && low_cnt >= ON_HOLD
        |-> ##[BOOT_LO:BOOT_HI] $rose(power_good_monitor))
        else $error("power good did not follow switch-on");
    a_off_hold_len: assert property (
        $rose(toggle_n) && power_good_monitor |-> low_cnt >= OFF_HOLD)
        else $error("switch-off hold too short");
    a_detach_released: assert property (
        !toggle_n |-> !$rose(detach_request))
        else $error("detach began while toggle held");
    a_detach_span: assert property (
        $fell(detach_request) |-> det_cnt >= DETACH_TIME && det_cnt <= DETACH_TIME + 1)
        else $error("detach phase length wrong");
    a_detach_then_off: assert property (
        $fell(detach_request) |-> ##[0:2] !power_good_monitor)
        else $error("power good stayed high after detach");
    a_off_has_cause: assert property (
        $fell(power_good_monitor) |-> det_seen || em_seen)
        else $error("switch-off without detach or emergency");
    a_emerg_hold_len: assert property (
        $rose(emergency_off_n) |-> em_cnt >= EMERG_HOLD)
        else $error("emergency hold too short");
    a_emerg_direct: assert property (
        $rose(emergency_off_n) && em_cnt >= EMERG_HOLD && power_good_monitor
        |-> !detach_request throughout (##[1:6] !power_good_monitor))
        else $error("emergency off late or with detach");
    a_pads_pull_only: assert property (
        (!toggle_oe_n |-> !toggle_o) and (!emergency_off_oe_n |-> !emergency_off_o))
        else $error("host drove a pad high");
endmodule : pwr_seq_sva

//--- verif/module_power_on_off_sequencer_tb.sv
// testbench: host and device ends joined, plus a bench-driven fault link
`timescale 1ns/1ps
`define CHECK(got, exp) check_val(4'(got), 4'(exp))
module module_power_on_off_sequencer_tb;
    localparam int unsigned ON_H = 50, OFF_H = 20, EM_H = 10, BOOT = 8, DET = 8;
    localparam int unsigned CMD_Q = 12, SER_Q = 8, MON_TO = 200;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start_on = 1'b0, start_off = 1'b0, start_emergency = 1'b0, sw_cmd = 1'b0;
    logic busy, module_on, commands_ok, timed_out, detach_request, powered;
    logic detach_2, powered_2;
    logic last_pg = 1'b0, det_seen = 1'b0, last_ok = 1'b0;
    int gap = 0;
    int bad_count = 0;
    int total_checks = 0;
    logic [1:0] exp_q[$];
    pwr_seq_if bus_if ();
    pwr_seq_if fault_if ();
    always #10 clk = ~clk;
    pwr_seq_host #(.ON_HOLD(ON_H), .OFF_HOLD(OFF_H), .EMERG_HOLD(EM_H), .CMD_QUIET(CMD_Q),
        .SERIAL_QUIET(SER_Q), .MON_TIMEOUT(MON_TO)) i_pwr_seq_host (.clk(clk), .rst_b(rst_b),
        .pads(bus_if.host), .start_on(start_on), .start_off(start_off),
        .start_emergency(start_emergency), .busy(busy), .module_on(module_on),
        .commands_ok(commands_ok), .timed_out(timed_out));
    pwr_seq_device #(.ON_HOLD(ON_H), .OFF_HOLD(OFF_H), .EMERG_HOLD(EM_H), .BOOT_TIME(BOOT),
        .DETACH_TIME(DET)) i_pwr_seq_device (.clk(clk), .rst_b(rst_b), .pads(bus_if.device),
        .software_shutdown_command(sw_cmd), .detach_request(detach_request), .powered(powered));
    pwr_seq_device #(.ON_HOLD(ON_H), .OFF_HOLD(OFF_H), .EMERG_HOLD(EM_H), .BOOT_TIME(BOOT),
        .DETACH_TIME(DET)) i_pwr_seq_device_fault (.clk(clk), .rst_b(rst_b),
        .pads(fault_if.device), .software_shutdown_command(1'b0), .detach_request(detach_2),
        .powered(powered_2));
    pwr_seq_sva #(.ON_HOLD(ON_H), .OFF_HOLD(OFF_H), .EMERG_HOLD(EM_H), .BOOT_TIME(BOOT),
        .DETACH_TIME(DET)) i_pwr_seq_sva (.clk(clk), .rst_b(rst_b),
        .toggle_o(bus_if.toggle_o), .toggle_oe_n(bus_if.toggle_oe_n),
        .emergency_off_o(bus_if.emergency_off_o),
        .emergency_off_oe_n(bus_if.emergency_off_oe_n),
        .power_good_monitor(bus_if.power_good_monitor), .toggle_n(bus_if.toggle_n),
        .emergency_off_n(bus_if.emergency_off_n), .detach_request(detach_request));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    // one-cycle request pulse; kind 0 on, 1 off, 2 software command, 3 emergency
    task automatic kick(input int kind);
        @(negedge clk);
        case (kind)
            0: start_on = 1'b1;
            1: start_off = 1'b1;
            2: sw_cmd = 1'b1;
            default: start_emergency = 1'b1;
        endcase
        @(negedge clk);
        {start_on, start_off, sw_cmd, start_emergency} = 4'h0;
    endtask : kick
    // bounded wait until the host is idle and no detach is running
    task automatic wait_settle();
        int n;
        n = 0;
        repeat (3) @(negedge clk);
        while ((busy !== 1'b0 || detach_request !== 1'b0) && n < 3000) begin
            @(negedge clk);
            n++;
        end
        `CHECK(n < 3000, 1'b1);
        repeat (4) @(negedge clk);
    endtask : wait_settle
    // the bench as host on the fault link: pulls a pad low, then releases it
    task automatic hold(input int pad, input int n);
        @(negedge clk);
        if (pad == 0) fault_if.toggle_oe_n = 1'b0;
        else fault_if.emergency_off_oe_n = 1'b0;
        repeat (n) @(negedge clk);
        `CHECK(detach_2, 1'b0);
        fault_if.toggle_oe_n = 1'b1;
        fault_if.emergency_off_oe_n = 1'b1;
    endtask : hold
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // observer
    // ------------------------------------------------------------
    // each power good edge takes the oldest note: {level, detach seen since}
    always @(negedge clk) begin
        if (rst_b === 1'b1) begin
            if (detach_request === 1'b1) det_seen = 1'b1;
            gap++;
            if (bus_if.power_good_monitor !== last_pg) begin
                if (exp_q.size() == 0) `CHECK(4'h0, 4'hF);
                else `CHECK({bus_if.power_good_monitor, det_seen}, exp_q.pop_front());
                last_pg = bus_if.power_good_monitor;
                det_seen = 1'b0;
                gap = 0;
            end
            if (commands_ok === 1'b1 && last_ok === 1'b0) `CHECK(gap >= CMD_Q && gap >= SER_Q, 1'b1);
            last_ok = commands_ok;
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        fault_if.toggle_o = 1'b0;
        fault_if.emergency_off_o = 1'b0;
        fault_if.toggle_oe_n = 1'b1;
        fault_if.emergency_off_oe_n = 1'b1;
        void'($urandom(32'hB7F8));
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        // every way off, each after a fresh switch-on
        for (int k = 1; k < 4; k++) begin
            exp_q.push_back(2'b10);
            kick(0);
            if (k == 1) kick(1); // ignored while busy
            wait_settle();
            `CHECK({module_on, powered}, 2'b11);
            `CHECK(commands_ok, 1'b1);
            kick(0);
            `CHECK(busy, 1'b0);
            repeat ($urandom_range(1, 20)) @(negedge clk);
            exp_q.push_back(k == 3 ? 2'b00 : 2'b01);
            kick(k);
            wait_settle();
            `CHECK({module_on, powered}, 2'b00);
        end
        `CHECK(timed_out, 1'b0);
        `CHECK(exp_q.size(), 0);
        // fault link: short holds must be ignored, full ones obeyed
        hold(0, $urandom_range(5, ON_H - 5));
        repeat (BOOT + 12) @(negedge clk);
        `CHECK(fault_if.power_good_monitor, 1'b0);
        hold(0, ON_H + $urandom_range(1, 5));
        repeat (BOOT + 12) @(negedge clk);
        `CHECK(fault_if.power_good_monitor, 1'b1);
        hold(1, $urandom_range(1, EM_H - 3));
        repeat (8) @(negedge clk);
        `CHECK(fault_if.power_good_monitor, 1'b1);
        hold(0, OFF_H + 4);
        repeat (4) @(negedge clk);
        `CHECK(detach_2, 1'b1);
        repeat (DET + 8) @(negedge clk);
        `CHECK(fault_if.power_good_monitor, 1'b0);
        hold(0, ON_H + 2);
        repeat (BOOT + 12) @(negedge clk);
        hold(1, EM_H + 3);
        repeat (8) @(negedge clk);
        `CHECK({fault_if.power_good_monitor, detach_2, powered_2}, 3'b000);
        results();
    end
    // watchdog: the whole run needs roughly seven hundred cycles
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        $display("unexpected watchdog expiry at %0t", $time);
        results();
    end
endmodule : module_power_on_off_sequencer_tb
